// ==== linescan_pkg.sv ====
package linescan_pkg;
   // Pixel positions and counts
   localparam int PIX_W = 8;
   localparam int SUM_W = 16;
   localparam int TIME_W = 16;
   localparam logic [7:0] FRAME_PIXELS = 8'h80;
   localparam logic [7:0] RELEASE_STROBES = 8'h81;
   localparam logic [15:0] PERCENT_SCALE = 16'h0064;
   // Register offsets (byte addresses)
   localparam int ADDR_W = 5;
   localparam logic [4:0] OFS_CTRL = 5'h00;
   localparam logic [4:0] OFS_TOL = 5'h04;
   localparam logic [4:0] OFS_CALCNT = 5'h08;
   localparam logic [4:0] OFS_STATUS = 5'h0c;
   localparam logic [4:0] OFS_MASK = 5'h10;
   localparam logic [4:0] OFS_RAW = 5'h14;
   localparam logic [4:0] OFS_FILT = 5'h18;
   localparam logic [4:0] OFS_AVG = 5'h1c;
   // Field positions
   localparam int CTRL_CAL = 0;
   localparam int CTRL_TRIG = 1;
   localparam int TOL_POS_LSB = 8;
   localparam int EV_OK = 0;
   localparam int EV_FAIL = 1;
   localparam int EV_CAL = 2;
   localparam int EV_W = 3;
   // Reset values
   localparam logic [7:0] RST_TOL_WIDTH = 8'h14;
   localparam logic [7:0] RST_TOL_POS = 8'h14;
   localparam logic [7:0] RST_CAL_FRAMES = 8'h08;
   localparam logic [2:0] RST_MASK = 3'h0;

   typedef enum logic [1:0] {
      MS_WAIT = 2'b00,
      MS_MEASURE = 2'b01,
      MS_FILTER = 2'b10
   } meas_state_t;

   typedef struct packed {
      logic [4:0] addr;
      logic [31:0] wrData;
      logic wr;
      logic rd;
   } bus_req_t;

   typedef struct packed {
      logic [1:0] syncStrobe;
      logic [1:0] syncPixel;
      logic [1:0] syncStart;
      logic strobeDly;
      logic startDly;
      logic resampled;
      logic resampledDly;
      logic [7:0] pixelCount;
      logic [7:0] frameLen;
      logic [7:0] capA;
      logic [7:0] capB;
      logic capFlag;
      logic endPend;
      logic [1:0] lowCount;
      logic [7:0] shortWidth;
      logic [7:0] shortPos;
      logic [7:0] longWidth;
      meas_state_t mstate;
      logic [7:0] rawWidth;
      logic [7:0] rawCenter;
      logic [7:0] filtWidth;
      logic [7:0] filtCenter;
      logic [7:0] avgWidth;
      logic [7:0] refCenter;
      logic [7:0] tolWidth;
      logic [7:0] tolPos;
      logic [7:0] calFrames;
      logic [7:0] calTotal;
      logic [7:0] calLeft;
      logic calActive;
      logic [15:0] sumWidth;
      logic [15:0] sumCenter;
      logic trigEn;
      logic [15:0] periodCnt;
      logic [15:0] period;
      logic [15:0] sinceRise;
      logic [15:0] sinceFall;
      logic convTrigger;
      logic [2:0] status;
      logic [2:0] mask;
      logic irq;
      logic [31:0] rdData;
   } state_t;
endpackage

// ==== linescan_line_pulse_measure.sv ====
`timescale 1ns/1ps
// Notes on behaviour
// - Resample threshold pixel on falling shift strobe
// - Frame must hold exactly two low pulses
// - Shorter low pulse is the line width
// - Longer low pulse is integration, never reported
// - Capture counts on start-pulse frame time base
// - Conversion trigger delayed a quarter strobe period
// - Report line position and width once per frame
// - Raw kept apart; filtered updated only on pass
// - Calibration averages width and position over frames
// - Measure waits capture flag, reads both edges
module linescan_line_pulse_measure (
   // Clock and reset
   input wire logic clock,
   input wire logic nrst,
   // Sensor side pins
   input wire logic pixelShiftStrobe,
   input wire logic serialStartPulse,
   input wire logic thresholdedPixel,
   output logic convTrigger,
   // Register port
   input wire linescan_pkg::bus_req_t busReq,
   output logic [31:0] rdData,
   // Interrupt
   output logic irq
);

   linescan_pkg::state_t cur;
   linescan_pkg::state_t next_cur;

   logic strobeRise;
   logic strobeFall;
   logic startRise;
   logic pixFall;
   logic pixRise;
   logic [7:0] widthNow;
   logic [7:0] widthDiff;
   logic [7:0] posDiff;
   logic widthOk;
   logic posOk;
   logic passBoth;
   logic [15:0] quarter;
   logic [2:0] evSet;
   logic [2:0] evClr;
   logic [7:0] divisor;

   function automatic logic [7:0] absDiff(input logic [7:0] a, input logic [7:0] b);
      absDiff = (a >= b) ? a - b : b - a;
   endfunction

   always_comb begin
      strobeRise = cur.syncStrobe[1] & ~cur.strobeDly;
      strobeFall = ~cur.syncStrobe[1] & cur.strobeDly;
      startRise = cur.syncStart[1] & ~cur.startDly;
      pixFall = cur.resampledDly & ~cur.resampled;
      pixRise = ~cur.resampledDly & cur.resampled;
      // Pulses that straddle a frame boundary wrap on the frame modulus
      if (cur.capB >= cur.capA) begin
         widthNow = cur.capB - cur.capA;
      end else begin
         widthNow = cur.capB + cur.frameLen - cur.capA;
      end
      widthDiff = absDiff(cur.shortWidth, cur.avgWidth);
      posDiff = absDiff(cur.shortPos, cur.refCenter);
      widthOk = {8'h00, widthDiff} * linescan_pkg::PERCENT_SCALE <=
                {8'h00, cur.avgWidth} * {8'h00, cur.tolWidth};
      posOk = {8'h00, posDiff} * linescan_pkg::PERCENT_SCALE <=
              {8'h00, cur.refCenter} * {8'h00, cur.tolPos};
      passBoth = widthOk & posOk;
      quarter = {2'b00, cur.period[15:2]};
      divisor = (cur.calTotal == 8'h00) ? 8'h01 : cur.calTotal;
   end

   always_comb begin
      next_cur = cur;
      evSet = 3'h0;
      evClr = 3'h0;
      // Pins pass two flops before anything looks at them
      next_cur.syncStrobe = {cur.syncStrobe[0], pixelShiftStrobe};
      next_cur.syncPixel = {cur.syncPixel[0], thresholdedPixel};
      next_cur.syncStart = {cur.syncStart[0], serialStartPulse};
      next_cur.strobeDly = cur.syncStrobe[1];
      next_cur.startDly = cur.syncStart[1];
      next_cur.resampledDly = cur.resampled;
      if (strobeFall) begin
         next_cur.resampled = cur.syncPixel[1];
      end

      // Frame-relative time base, restarted by the start pulse
      if (startRise) begin
         next_cur.pixelCount = 8'h00;
         next_cur.frameLen = cur.pixelCount;
         next_cur.endPend = 1'b1;
      end else if (strobeRise && cur.pixelCount != 8'hff) begin
         next_cur.pixelCount = cur.pixelCount + 8'h01;
      end

      // Capture channel: A on falling edge, B and flag on rising edge
      if (pixFall) begin
         next_cur.capA = cur.pixelCount;
      end
      if (pixRise) begin
         next_cur.capB = cur.pixelCount;
      end

      case (cur.mstate)
         linescan_pkg::MS_WAIT: begin
            if (cur.capFlag) begin
               next_cur.capFlag = 1'b0;
               next_cur.mstate = linescan_pkg::MS_MEASURE;
            end else if (cur.endPend) begin
               next_cur.endPend = 1'b0;
               next_cur.mstate = linescan_pkg::MS_FILTER;
            end
         end
         linescan_pkg::MS_MEASURE: begin
            if (cur.lowCount != 2'b11) begin
               next_cur.lowCount = cur.lowCount + 2'b01;
            end
            if (cur.lowCount == 2'b00 || widthNow < cur.shortWidth) begin
               next_cur.longWidth = (cur.lowCount == 2'b00) ? widthNow : cur.shortWidth;
               next_cur.shortWidth = widthNow;
               next_cur.shortPos = cur.capA + {1'b0, widthNow[7:1]};
            end else begin
               next_cur.longWidth = widthNow;
            end
            next_cur.mstate = linescan_pkg::MS_WAIT;
         end
         linescan_pkg::MS_FILTER: begin
            if (cur.lowCount != 2'b10) begin
               evSet[linescan_pkg::EV_FAIL] = 1'b1;
            end else begin
               next_cur.rawWidth = cur.shortWidth;
               next_cur.rawCenter = cur.shortPos;
               if (cur.calActive) begin
                  next_cur.sumWidth = cur.sumWidth + {8'h00, cur.shortWidth};
                  next_cur.sumCenter = cur.sumCenter + {8'h00, cur.shortPos};
                  next_cur.calLeft = cur.calLeft - 8'h01;
                  if (cur.calLeft == 8'h01) begin
                     next_cur.calActive = 1'b0;
                     next_cur.avgWidth = 8'((cur.sumWidth + {8'h00, cur.shortWidth}) / {8'h00, divisor});
                     next_cur.refCenter = 8'((cur.sumCenter + {8'h00, cur.shortPos}) / {8'h00, divisor});
                     evSet[linescan_pkg::EV_CAL] = 1'b1;
                  end
               end else if (passBoth) begin
                  next_cur.filtWidth = cur.shortWidth;
                  next_cur.filtCenter = cur.shortPos;
                  next_cur.refCenter = cur.shortPos;
                  evSet[linescan_pkg::EV_OK] = 1'b1;
               end else begin
                  evSet[linescan_pkg::EV_FAIL] = 1'b1;
               end
            end
            next_cur.lowCount = 2'b00;
            next_cur.mstate = linescan_pkg::MS_WAIT;
         end
         default: begin
            next_cur.mstate = linescan_pkg::MS_WAIT;
         end
      endcase
      // A capture arriving while the flag is consumed is kept
      if (pixRise) begin
         next_cur.capFlag = 1'b1;
      end

      // Quarter-period delayed copy of the shift strobe
      if (strobeRise) begin
         next_cur.period = cur.periodCnt + 16'h0001;
         next_cur.periodCnt = 16'h0000;
         next_cur.sinceRise = 16'h0000;
      end else begin
         next_cur.periodCnt = (cur.periodCnt == 16'hffff) ? cur.periodCnt : cur.periodCnt + 16'h0001;
         next_cur.sinceRise = (cur.sinceRise == 16'hffff) ? cur.sinceRise : cur.sinceRise + 16'h0001;
      end
      if (strobeFall) begin
         next_cur.sinceFall = 16'h0000;
      end else begin
         next_cur.sinceFall = (cur.sinceFall == 16'hffff) ? cur.sinceFall : cur.sinceFall + 16'h0001;
      end
      if (!cur.trigEn) begin
         next_cur.convTrigger = 1'b0;
      end else if (cur.syncStrobe[1] && cur.sinceRise == quarter) begin
         next_cur.convTrigger = 1'b1;
      end else if (!cur.syncStrobe[1] && cur.sinceFall == quarter) begin
         next_cur.convTrigger = 1'b0;
      end

      // Register writes
      if (busReq.wr) begin
         case (busReq.addr)
            linescan_pkg::OFS_CTRL: begin
               next_cur.trigEn = busReq.wrData[linescan_pkg::CTRL_TRIG];
               if (busReq.wrData[linescan_pkg::CTRL_CAL]) begin
                  next_cur.calActive = 1'b1;
                  next_cur.calTotal = cur.calFrames;
                  next_cur.calLeft = (cur.calFrames == 8'h00) ? 8'h01 : cur.calFrames;
                  next_cur.sumWidth = 16'h0000;
                  next_cur.sumCenter = 16'h0000;
               end
            end
            linescan_pkg::OFS_TOL: begin
               next_cur.tolWidth = busReq.wrData[7:0];
               next_cur.tolPos = busReq.wrData[linescan_pkg::TOL_POS_LSB +: 8];
            end
            linescan_pkg::OFS_CALCNT: begin
               next_cur.calFrames = busReq.wrData[7:0];
            end
            linescan_pkg::OFS_STATUS: begin
               evClr = busReq.wrData[linescan_pkg::EV_W-1:0];
            end
            linescan_pkg::OFS_MASK: begin
               next_cur.mask = busReq.wrData[linescan_pkg::EV_W-1:0];
            end
            default: begin
            end
         endcase
      end
      // Set wins over a write-one clear in the same cycle
      next_cur.status = (cur.status & ~evClr) | evSet;
      next_cur.irq = |(next_cur.status & next_cur.mask);

      // Read data stands one cycle after the strobe; zero otherwise
      next_cur.rdData = 32'h0000_0000;
      if (busReq.rd) begin
         case (busReq.addr)
            linescan_pkg::OFS_CTRL: next_cur.rdData = {29'h0, cur.calActive, cur.trigEn, 1'b0};
            linescan_pkg::OFS_TOL: next_cur.rdData = {16'h0000, cur.tolPos, cur.tolWidth};
            linescan_pkg::OFS_CALCNT: next_cur.rdData = {16'h0000, cur.calLeft, cur.calFrames};
            linescan_pkg::OFS_STATUS: next_cur.rdData = {29'h0, cur.status};
            linescan_pkg::OFS_MASK: next_cur.rdData = {29'h0, cur.mask};
            linescan_pkg::OFS_RAW: next_cur.rdData = {16'h0000, cur.rawCenter, cur.rawWidth};
            linescan_pkg::OFS_FILT: next_cur.rdData = {16'h0000, cur.filtCenter, cur.filtWidth};
            linescan_pkg::OFS_AVG: next_cur.rdData = {16'h0000, cur.refCenter, cur.avgWidth};
            default: next_cur.rdData = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         cur <= '0;
         cur.mstate <= linescan_pkg::MS_WAIT;
         cur.tolWidth <= linescan_pkg::RST_TOL_WIDTH;
         cur.tolPos <= linescan_pkg::RST_TOL_POS;
         cur.calFrames <= linescan_pkg::RST_CAL_FRAMES;
         cur.mask <= linescan_pkg::RST_MASK;
      end else begin
         cur <= next_cur;
      end
   end

   assign convTrigger = cur.convTrigger;
   assign rdData = cur.rdData;
   assign irq = cur.irq;

   a_resample_on_fall: assert property (@(posedge clock) disable iff (!nrst)
      strobeFall |=> cur.resampled == $past(cur.syncPixel[1]))
      else $error("pixel not resampled on strobe fall");

   a_pulse_count_fail: assert property (@(posedge clock) disable iff (!nrst)
      (cur.mstate == linescan_pkg::MS_FILTER && cur.lowCount != 2'b10) |=> cur.status[linescan_pkg::EV_FAIL])
      else $error("bad pulse count not flagged");

   a_short_is_line: assert property (@(posedge clock) disable iff (!nrst)
      (cur.mstate == linescan_pkg::MS_FILTER && cur.lowCount == 2'b10) |=> cur.rawWidth == $past(cur.shortWidth))
      else $error("raw width is not the shorter pulse");

   a_long_not_line: assert property (@(posedge clock) disable iff (!nrst)
      (cur.lowCount == 2'b10) |-> cur.shortWidth <= cur.longWidth)
      else $error("longer pulse taken as line");

   a_frame_restart: assert property (@(posedge clock) disable iff (!nrst)
      startRise |=> cur.pixelCount == 8'h00 && cur.frameLen == $past(cur.pixelCount))
      else $error("time base not restarted by start pulse");

   a_trigger_quarter: assert property (@(posedge clock) disable iff (!nrst)
      (cur.trigEn && cur.syncStrobe[1] && cur.sinceRise == quarter && $stable(cur.trigEn)) |=> cur.convTrigger)
      else $error("trigger not raised a quarter period late");

   a_center_reported: assert property (@(posedge clock) disable iff (!nrst)
      (cur.mstate == linescan_pkg::MS_FILTER && cur.lowCount == 2'b10) |=> cur.rawCenter == $past(cur.shortPos))
      else $error("line position not reported");

   a_filtered_pass: assert property (@(posedge clock) disable iff (!nrst)
      $changed(cur.filtWidth) |-> $past(cur.mstate == linescan_pkg::MS_FILTER && passBoth && !cur.calActive))
      else $error("filtered width updated without passing");

   a_position_reject: assert property (@(posedge clock) disable iff (!nrst)
      (cur.mstate == linescan_pkg::MS_FILTER && cur.lowCount == 2'b10 && !cur.calActive && !posOk)
      |=> cur.status[linescan_pkg::EV_FAIL] && $stable(cur.filtCenter))
      else $error("position out of tolerance accepted");

   a_width_reject: assert property (@(posedge clock) disable iff (!nrst)
      (cur.mstate == linescan_pkg::MS_FILTER && cur.lowCount == 2'b10 && !cur.calActive && !widthOk)
      |=> $stable(cur.filtWidth))
      else $error("width out of tolerance accepted");

   a_capture_flow: assert property (@(posedge clock) disable iff (!nrst)
      (cur.mstate == linescan_pkg::MS_WAIT && cur.capFlag) |=> cur.mstate == linescan_pkg::MS_MEASURE ##1
      cur.mstate == linescan_pkg::MS_WAIT)
      else $error("capture flag not followed by measurement");

   // Calibration frames still being summed raise no outcome of their own
   a_outcome_flagged: assert property (@(posedge clock) disable iff (!nrst)
      (cur.mstate == linescan_pkg::MS_FILTER && !(cur.calActive && cur.lowCount == 2'b10 && cur.calLeft != 8'h01))
      |=> (cur.status != 3'h0))
      else $error("frame ended with no outcome");

   a_cal_done: assert property (@(posedge clock) disable iff (!nrst)
      $fell(cur.calActive) |-> cur.status[linescan_pkg::EV_CAL])
      else $error("calibration end not flagged");

   a_irq_level: assert property (@(posedge clock) disable iff (!nrst)
      cur.irq == |(cur.status & cur.mask))
      else $error("interrupt does not follow masked status");

   a_trigger_off: assert property (@(posedge clock) disable iff (!nrst)
      !cur.trigEn |=> !cur.convTrigger)
      else $error("trigger active while disabled");

   a_trigger_fall: assert property (@(posedge clock) disable iff (!nrst)
      (cur.trigEn && !cur.syncStrobe[1] && cur.sinceFall == quarter) |=> !cur.convTrigger)
      else $error("trigger not lowered a quarter period late");

   a_raw_kept: assert property (@(posedge clock) disable iff (!nrst)
      (cur.mstate == linescan_pkg::MS_FILTER && cur.lowCount != 2'b10)
      |=> $stable(cur.rawWidth) && $stable(cur.rawCenter))
      else $error("raw values changed by a rejected frame");

   a_cal_no_filter: assert property (@(posedge clock) disable iff (!nrst)
      (cur.mstate == linescan_pkg::MS_FILTER && cur.calActive)
      |=> $stable(cur.filtWidth) && $stable(cur.filtCenter))
      else $error("filtered values changed during calibration");

   a_capture_start: assert property (@(posedge clock) disable iff (!nrst)
      pixFall |=> cur.capA == $past(cur.pixelCount))
      else $error("capture A not taken at pulse start");

   a_first_width: assert property (@(posedge clock) disable iff (!nrst)
      (cur.mstate == linescan_pkg::MS_MEASURE && cur.lowCount == 2'b00) |=> cur.shortWidth == $past(widthNow))
      else $error("pulse width not taken from the capture pair");

endmodule

// ==== linescan_sensor_model.sv ====
`timescale 1ns/1ps
module linescan_sensor_model (
   // Clock used only to pace the pins
   input wire logic clock,
   // Pins toward the block
   output logic pixelShiftStrobe,
   output logic serialStartPulse,
   output logic thresholdedPixel
);
   initial begin
      pixelShiftStrobe = 1'b0;
      serialStartPulse = 1'b0;
      thresholdedPixel = 1'b1;
   end

   // One frame: dark line at [lineStart, lineStart + lineWidth), integration dark at 100..119.
   // A width of 0 leaves only the integration pulse in the frame.
   task automatic run_frame(input int lineStart, input int lineWidth);
      int p;
      @(posedge clock);
      serialStartPulse <= 1'b1;
      repeat (4) @(posedge clock);
      serialStartPulse <= 1'b0;
      for (p = 0; p < 129; p++) begin
         pixelShiftStrobe <= 1'b1;
         thresholdedPixel <= !((p >= lineStart && p < lineStart + lineWidth) || (p >= 100 && p < 120));
         repeat (4) @(posedge clock);
         pixelShiftStrobe <= 1'b0;
         repeat (4) @(posedge clock);
      end
      // All pixels released: strobe rests low, the output no longer holds the last pixel
      thresholdedPixel <= !thresholdedPixel;
      repeat (8) @(posedge clock);
   endtask
endmodule

// ==== tb_linescan_line_pulse_measure.sv ====
`timescale 1ns/1ps
`define CHK(name, exp, got) \
   begin \
      checks++; \
      if ((got) !== (exp)) begin \
         errors++; \
         $display("mismatch %s expected %0h seen %0h", name, exp, got); \
      end \
   end
module tb_linescan_line_pulse_measure;
   logic clock;
   logic nrst;
   logic pixelShiftStrobe;
   logic serialStartPulse;
   logic thresholdedPixel;
   logic convTrigger;
   linescan_pkg::bus_req_t busReq;
   logic [31:0] rdData;
   logic irq;
   logic [31:0] d;
   logic [7:0] cal;
   int errors;
   int checks;
   int cycles;
   int hi;
   realtime ts;

   linescan_line_pulse_measure dut (
      .clock(clock),
      .nrst(nrst),
      .pixelShiftStrobe(pixelShiftStrobe),
      .serialStartPulse(serialStartPulse),
      .thresholdedPixel(thresholdedPixel),
      .convTrigger(convTrigger),
      .busReq(busReq),
      .rdData(rdData),
      .irq(irq)
   );

   linescan_sensor_model sensor (
      .clock(clock),
      .pixelShiftStrobe(pixelShiftStrobe),
      .serialStartPulse(serialStartPulse),
      .thresholdedPixel(thresholdedPixel)
   );

   always #50 clock = ~clock;

   // Nine frames of about 1050 cycles each, plus bus traffic
   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         errors++;
         finish_test();
      end
   end

   task automatic finish_test();
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   task automatic wr(input logic [4:0] a, input logic [31:0] v);
      @(posedge clock);
      busReq <= '{addr: a, wrData: v, wr: 1'b1, rd: 1'b0};
      @(posedge clock);
      busReq.wr <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe, so sample just past that edge
   task automatic rd(input logic [4:0] a);
      @(posedge clock);
      busReq <= '{addr: a, wrData: 32'h0, wr: 1'b0, rd: 1'b1};
      @(posedge clock);
      busReq.rd <= 1'b0;
      #1 d = rdData;
   endtask

   // Frames are judged at the next start pulse, so this checks the frame before the last one sent.
   // Centers are compared as offsets from the calibrated reference, which hides the capture latency.
   task automatic verdict(input logic [2:0] st, input logic [7:0] rw, input logic [7:0] rc,
                          input logic [7:0] fw, input logic [7:0] fc);
      `CHK("irq", st[linescan_pkg::EV_FAIL], irq)
      rd(linescan_pkg::OFS_STATUS);
      `CHK("status", {29'h0, st}, d)
      rd(linescan_pkg::OFS_RAW);
      `CHK("raw width", rw, d[7:0])
      `CHK("raw center", rc, d[15:8] - cal)
      rd(linescan_pkg::OFS_FILT);
      `CHK("filtered width", fw, d[7:0])
      `CHK("filtered center", fc, d[15:8] - cal)
      wr(linescan_pkg::OFS_STATUS, 32'h7);
   endtask

   initial begin
      clock = 1'b0;
      nrst = 1'b0;
      busReq = '0;
      errors = 0;
      checks = 0;
      cycles = 0;
      cal = 8'h00;
      repeat (10) @(posedge clock);
      nrst <= 1'b1;
      rd(linescan_pkg::OFS_TOL);
      `CHK("tolerance reset", 32'h00001414, d)
      @(posedge clock);
      #1;
      `CHK("read data one cycle", 32'h0, rdData)
      rd(linescan_pkg::OFS_CALCNT);
      `CHK("frame count reset", 8'h08, d[7:0])
      rd(linescan_pkg::OFS_MASK);
      `CHK("mask reset", 32'h0, d)
      rd(linescan_pkg::OFS_AVG);
      `CHK("average reset", 32'h0, d)
      wr(5'h02, 32'hffffffff);
      rd(5'h02);
      `CHK("unmapped", 32'h0, d)
      wr(linescan_pkg::OFS_CALCNT, 32'h2);
      wr(linescan_pkg::OFS_CTRL, 32'h2);
      sensor.run_frame(40, 10);
      wr(linescan_pkg::OFS_MASK, 32'h4);
      wr(linescan_pkg::OFS_CTRL, 32'h3);
      rd(linescan_pkg::OFS_CTRL);
      `CHK("calibrating", 2'b11, d[2:1])
      fork
         sensor.run_frame(40, 10);
         begin
            repeat (20) @(posedge pixelShiftStrobe);
            ts = $realtime;
            @(posedge convTrigger);
            `CHK("trigger delay", 1'b1, ($realtime - ts) >= 200.0 && ($realtime - ts) < 800.0)
            hi = 0;
            repeat (80) begin
               @(negedge clock);
               if (convTrigger === 1'b1) hi++;
            end
            `CHK("trigger duty", 40, hi)
         end
      join
      sensor.run_frame(40, 10);
      sensor.run_frame(40, 12);
      `CHK("cal irq", 1'b1, irq)
      rd(linescan_pkg::OFS_STATUS);
      `CHK("cal done", 1'b1, d[linescan_pkg::EV_CAL])
      rd(linescan_pkg::OFS_CALCNT);
      `CHK("frames left", 8'h00, d[15:8])
      rd(linescan_pkg::OFS_AVG);
      `CHK("average width", 8'h0a, d[7:0])
      // The counter steps on each strobe before its pixel is resampled, so pixel 40 counts as 41
      `CHK("reference center", 8'd46, d[15:8])
      cal = 8'd46;
      wr(linescan_pkg::OFS_STATUS, 32'h7);
      rd(linescan_pkg::OFS_STATUS);
      `CHK("status cleared", 32'h0, d)
      `CHK("irq cleared", 1'b0, irq)
      wr(linescan_pkg::OFS_MASK, 32'h2);
      sensor.run_frame(40, 13);
      verdict(3'h1, 8'd12, 8'd1, 8'd12, 8'd1);
      sensor.run_frame(44, 10);
      verdict(3'h2, 8'd13, 8'd1, 8'd12, 8'd1);
      sensor.run_frame(80, 10);
      verdict(3'h1, 8'd10, 8'd4, 8'd10, 8'd4);
      sensor.run_frame(80, 0);
      verdict(3'h2, 8'd10, 8'd40, 8'd10, 8'd4);
      sensor.run_frame(40, 10);
      verdict(3'h2, 8'd10, 8'd40, 8'd10, 8'd4);
      finish_test();
   end
endmodule
